/* logic/parallel_io_pkg.sv */
package parallel_io_pkg;
    localparam int NUM_PORTS = 5;
    localparam int PORT_BITS = 8;
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;

    typedef logic [NUM_PORTS-1:0][PORT_BITS-1:0] port_bus_t;

    // Bits that exist: port D has seven pins
    localparam port_bus_t IMPL_MASK = {8'hff, 8'h7f, 8'hff, 8'hff, 8'hff};
    // Bits with an output driver: port A bit 0 is input only
    localparam port_bus_t DRIVE_MASK = {8'hff, 8'h7f, 8'hff, 8'hff, 8'hfe};

    // Register map, byte addresses within the slave
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_PULLUP = 8'h04;
    localparam logic [7:0] OFF_DIR = 8'h08;
    localparam logic [7:0] OFF_PIN_MUX = 8'h50;
    localparam logic [7:0] OFF_KBI_SEL = 8'h54;

    // Pin mux control fields
    typedef struct packed {
        logic reset_pin_en;
        logic bkgd_en;
        logic tmr0_en;
        logic tmr1_en;
        logic spi_en;
        logic sci_en;
    } pin_mux_t;

    localparam pin_mux_t PIN_MUX_RST = 6'h30;
    localparam port_bus_t PORT_RST = '0;
    localparam logic [11:0] KBI_SEL_RST = 12'h000;
    localparam int KEYBOARD_INTERRUPT_ONE_SEL_LSB = 0;
    localparam int KEYBOARD_INTERRUPT_TWO_SEL_LSB = 8;
    localparam int SPI_FIRST_BIT = 4;

    // Signals from on-chip peripherals that may take over pins
    typedef struct packed {
        logic sci_txd;
        logic [3:0] spi_out;
        logic [3:0] spi_oe;
        logic tmr1_out;
        logic tmr1_oe;
        logic tmr0_out;
        logic tmr0_oe;
        logic bkgd_out;
        logic bkgd_oe;
    } periph_drive_t;

    // Synchronised pin levels handed to the peripherals
    typedef struct packed {
        logic [7:0] keyboard_interrupt_one_in;
        logic [3:0] keyboard_interrupt_two_in;
        logic sci_rxd;
        logic [3:0] spi_in;
        logic tmr1_in;
        logic tmr0_in;
        logic bkgd_in;
        logic reset_level;
    } periph_sense_t;

    typedef enum logic [1:0] {
        CAP_WAIT1 = 2'b00,
        CAP_WAIT2 = 2'b01,
        CAP_WAIT3 = 2'b11,
        CAP_DONE = 2'b10
    } cap_state_t;

    typedef struct packed {
        port_bus_t data;
        port_bus_t dir;
        port_bus_t pe;
        port_bus_t sync1;
        port_bus_t sync2;
        port_bus_t pin_out;
        port_bus_t pin_oe;
        port_bus_t pin_pu;
        pin_mux_t mux;
        logic [11:0] kbi_sel;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        cap_state_t cap;
        logic mode_select;
    } state_t;

    function automatic logic [7:0] reg_addr(input int p, input logic [7:0] off);
        logic [7:0] base;
        base = 8'(p) * PORT_STRIDE;
        return base + off;
    endfunction
endpackage

/* logic/parallel_io.sv */
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
module parallel_io
    import parallel_io_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire port_bus_t pin_in,
    output port_bus_t pin_out,
    output port_bus_t pin_oe,
    output port_bus_t pin_pullup,
    input wire periph_drive_t periph_drive,
    output periph_sense_t periph_sense,
    output logic mode_select
);
    state_t s;
    state_t n;
    logic accept;
    logic own;
    logic p_oe;
    logic p_out;
    logic drive;
    logic [7:0] rd_val;

    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = 1'b0;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign pin_pullup = s.pin_pu;
    assign mode_select = s.mode_select;

    // Peripheral inputs see synchronised levels only
    assign periph_sense.keyboard_interrupt_one_in = s.sync2[PORT_A] & s.kbi_sel[KEYBOARD_INTERRUPT_ONE_SEL_LSB +: 8];
    assign periph_sense.keyboard_interrupt_two_in = s.sync2[PORT_C][3:0] & s.kbi_sel[KEYBOARD_INTERRUPT_TWO_SEL_LSB +: 4];
    assign periph_sense.sci_rxd = s.sync2[PORT_B][1];
    assign periph_sense.spi_in = s.sync2[PORT_C][7:4];
    assign periph_sense.tmr1_in = s.sync2[PORT_B][7];
    assign periph_sense.tmr0_in = s.sync2[PORT_D][6];
    assign periph_sense.bkgd_in = s.sync2[PORT_D][0];
    assign periph_sense.reset_level = s.sync2[PORT_D][1];

    always_comb begin
        n = s;
        own = 1'b0;
        p_oe = 1'b0;
        p_out = 1'b0;
        drive = 1'b0;
        rd_val = 8'h00;
        accept = hsel & hready & htrans[1];

        n.sync1 = pin_in & IMPL_MASK;
        n.sync2 = s.sync1;
        n.hreadyout = 1'b1;

        // Data phase of a write: hwdata is valid now
        if (s.wr_pend) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (s.wr_addr == reg_addr(p, OFF_DATA)) begin
                    n.data[p] = hwdata[7:0] & IMPL_MASK[p];
                end else if (s.wr_addr == reg_addr(p, OFF_PULLUP)) begin
                    n.pe[p] = hwdata[7:0] & IMPL_MASK[p];
                end else if (s.wr_addr == reg_addr(p, OFF_DIR)) begin
                    n.dir[p] = hwdata[7:0] & IMPL_MASK[p];
                end
            end
            if (s.wr_addr == OFF_PIN_MUX) begin
                n.mux = hwdata[5:0];
            end else if (s.wr_addr == OFF_KBI_SEL) begin
                n.kbi_sel = hwdata[11:0];
            end
        end

        // Address phase: capture write target, or form read data at once
        n.wr_pend = accept & hwrite;
        n.wr_addr = haddr[7:0];
        n.hrdata = 32'h00000000;
        if (accept && !hwrite) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (haddr[7:0] == reg_addr(p, OFF_DATA)) begin
                    // Direction bit picks the source even for owned pins, except D1:D0, which always read the pin
                    rd_val = (n.dir[p] & n.data[p]) | (~n.dir[p] & s.sync2[p]);
                    if (p == PORT_D) begin
                        rd_val[1:0] = s.sync2[p][1:0];
                    end
                end else if (haddr[7:0] == reg_addr(p, OFF_PULLUP)) begin
                    rd_val = n.pe[p];
                end else if (haddr[7:0] == reg_addr(p, OFF_DIR)) begin
                    rd_val = n.dir[p];
                end
            end
            if (haddr[7:0] == OFF_PIN_MUX) begin
                n.hrdata = {26'h0000000, n.mux};
            end else if (haddr[7:0] == OFF_KBI_SEL) begin
                n.hrdata = {20'h00000, n.kbi_sel};
            end else begin
                n.hrdata = {24'h000000, rd_val};
            end
        end

        // Pin ownership and drive, per pin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < PORT_BITS; b++) begin
                own = 1'b0;
                p_oe = 1'b0;
                p_out = 1'b0;
                if (p == PORT_A && s.kbi_sel[KEYBOARD_INTERRUPT_ONE_SEL_LSB + b]) begin
                    own = 1'b1;
                end
                if (p == PORT_B && b == 0 && s.mux.sci_en) begin
                    own = 1'b1;
                    p_oe = 1'b1;
                    p_out = periph_drive.sci_txd;
                end
                if (p == PORT_B && b == 1 && s.mux.sci_en) begin
                    own = 1'b1;
                end
                if (p == PORT_B && b == 7 && s.mux.tmr1_en) begin
                    own = 1'b1;
                    p_oe = periph_drive.tmr1_oe;
                    p_out = periph_drive.tmr1_out;
                end
                if (p == PORT_C && b >= SPI_FIRST_BIT && s.mux.spi_en) begin
                    own = 1'b1;
                    p_oe = periph_drive.spi_oe[b - SPI_FIRST_BIT];
                    p_out = periph_drive.spi_out[b - SPI_FIRST_BIT];
                end
                if (p == PORT_C && b < SPI_FIRST_BIT && s.kbi_sel[KEYBOARD_INTERRUPT_TWO_SEL_LSB + (b % 4)]) begin
                    own = 1'b1;
                end
                if (p == PORT_D && b == 0 && s.mux.bkgd_en) begin
                    own = 1'b1;
                    p_oe = periph_drive.bkgd_oe;
                    p_out = periph_drive.bkgd_out;
                end
                if (p == PORT_D && b == 1 && s.mux.reset_pin_en) begin
                    own = 1'b1;
                end
                if (p == PORT_D && b == 6 && s.mux.tmr0_en) begin
                    own = 1'b1;
                    p_oe = periph_drive.tmr0_oe;
                    p_out = periph_drive.tmr0_out;
                end

                drive = own ? p_oe : s.dir[p][b];
                drive = drive & DRIVE_MASK[p][b];
                n.pin_oe[p][b] = drive;
                n.pin_out[p][b] = drive & (own ? p_out : s.data[p][b]);
                // Pullup only on an input whose direction bit is 0, or on D0 whenever bkgd_en is set
                n.pin_pu[p][b] = s.pe[p][b] & ~s.dir[p][b] & ~drive
                    & IMPL_MASK[p][b];
                if (p == PORT_D && b == 0 && s.mux.bkgd_en) begin
                    n.pin_pu[p][b] = 1'b1;
                end
            end
        end

        // Mode-select strap: sampled once the synchroniser has settled
        case (s.cap)
            CAP_WAIT1: begin
                n.cap = CAP_WAIT2;
            end
            CAP_WAIT2: begin
                n.cap = CAP_WAIT3;
            end
            CAP_WAIT3: begin
                n.cap = CAP_DONE;
                n.mode_select = s.sync2[PORT_D][0];
            end
            default: begin
                n.cap = CAP_DONE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.data <= PORT_RST;
            s.dir <= PORT_RST;
            s.pe <= PORT_RST;
            s.mux <= PIN_MUX_RST;
            s.kbi_sel <= KBI_SEL_RST;
            s.pin_pu <= 40'h0000000001 << 24;
            s.hreadyout <= 1'b1;
            s.cap <= CAP_WAIT1;
        end else begin
            s <= n;
        end
    end
endmodule

/* sim/pin_model.sv */
`timescale 1ns/1ns
module pin_model
    import parallel_io_pkg::*;
(
    input wire logic hclk,
    input wire port_bus_t pin_out,
    input wire port_bus_t pin_oe,
    input wire port_bus_t pin_pullup,
    input wire port_bus_t ext_val,
    input wire port_bus_t ext_en,
    output port_bus_t pin_in
);
    port_bus_t noise = '0;
    // Floating pins change every cycle so no stale level can pass
    always @(posedge hclk) noise <= ~noise;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | noise));
endmodule

/* sim/parallel_io_chk.sv */
`timescale 1ns/1ns
module parallel_io_chk
    import parallel_io_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire port_bus_t pin_in,
    input wire port_bus_t pin_out,
    input wire port_bus_t pin_oe,
    input wire port_bus_t pin_pullup,
    input wire periph_sense_t periph_sense,
    input wire logic mode_select
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_a0_undriven: assert property (!pin_oe[0][0]) else $error("A0 driven");
    a_d7_absent: assert property (!pin_oe[3][7] && !pin_pullup[3][7]) else $error("D7 used");
    a_pullup_input: assert property ((pin_pullup & pin_oe & ~40'h1000000) == '0)
        else $error("Pullup on driven pin");
    a_out_masked: assert property ((pin_out & ~pin_oe) == '0) else $error("Out without oe");
    a_rxd_sync: assert property ($past(hresetn) && $past(hresetn, 2)
        |-> periph_sense.sci_rxd == $past(pin_in[1][1], 2)) else $error("Rx sense late");
    a_reset_sense: assert property ($past(hresetn) && $past(hresetn, 2)
        |-> periph_sense.reset_level == $past(pin_in[3][1], 2)) else $error("Reset sense");
    a_mode_hold: assert property ($past(hresetn, 4) |-> $stable(mode_select))
        else $error("Mode select moved");
    a_rdata_idle: assert property (hrdata != '0 |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("Read data outside read");
    a_reset_state: assert property (disable iff (1'b0) !hresetn
        |-> pin_oe == '0 && pin_pullup == 40'h1000000) else $error("Reset pin state");
endmodule

bind parallel_io parallel_io_chk u_chk (.*);

/* sim/tb_five_port_parallel_io.sv */
`timescale 1ns/1ns
module tb_five_port_parallel_io;
    import parallel_io_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, mode_select;
    logic [31:0] hrdata, rd;
    wire hready = hreadyout;
    port_bus_t pin_in, pin_out, pin_oe, pin_pullup;
    port_bus_t ext_val = 40'h1000000;
    port_bus_t ext_en = '1;
    periph_drive_t periph_drive = '0;
    periph_sense_t periph_sense;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
    initial forever #5 hclk = ~hclk;
    parallel_io u_dut (.*);
    pin_model u_pins (.*);
    task automatic conclude();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic t_reset();
        `CHK(mode_select, 1'b1)
        `CHK(pin_oe, 40'h0)
        `CHK(pin_pullup, 40'h1000000)
        `CHK(hresp, 1'b0)
        rdchk(OFF_PIN_MUX, 32'h30);
        for (int p = 0; p < NUM_PORTS; p++) rdchk(8'(p) * PORT_STRIDE + OFF_DIR, 0);
        // Background drives D0 high, D1 stays with reset; both read the pin, not the latch
        periph_drive <= 15'h0003;
        wr(8'h38, 32'h03);
        repeat (2) @(posedge hclk);
        `CHK(pin_oe[3], 8'h01)
        rdchk(8'h30, 32'h01);
        periph_drive <= '0;
        wr(8'h38, 0);
        $display("t_reset done");
    endtask
    task automatic t_gpio();
        logic [7:0] b;
        wr(OFF_PIN_MUX, 0);
        ext_val <= {5{8'h3c}};
        wr(8'h80, 32'h1);
        rdchk(8'h80, 0);
        for (int p = 0; p < NUM_PORTS; p++) begin
            b = 8'(p) * PORT_STRIDE;
            wr(b, 32'hffffffa5);
            rdchk(b, {24'h0, 8'h3c & IMPL_MASK[p]});
            wr(b + OFF_DIR, 32'hff);
            repeat (2) @(posedge hclk);
            `CHK(pin_oe[p], DRIVE_MASK[p])
            `CHK(pin_out[p], 8'ha5 & DRIVE_MASK[p])
            rdchk(b, {24'h0, 8'ha5 & IMPL_MASK[p]});
            wr(b + OFF_DIR, 0);
        end
        $display("t_gpio done");
    endtask
    task automatic t_pullup();
        ext_en[4] <= 8'h00;
        wr(8'h44, 32'hff);
        wr(8'h48, 32'h0f);
        repeat (2) @(posedge hclk);
        `CHK(pin_pullup[4], 8'hf0)
        rdchk(8'h40, 32'hf5);
        wr(8'h48, 0);
        repeat (2) @(posedge hclk);
        `CHK(pin_pullup[4], 8'hff)
        rdchk(8'h40, 32'hff);
        ext_en <= '1;
        $display("t_pullup done");
    endtask
    task automatic t_periph();
        wr(OFF_PIN_MUX, 32'h0f);
        wr(8'h14, 32'h02);
        periph_drive <= 15'h7cbc;
        repeat (3) @(posedge hclk);
        `CHK(pin_oe[1], 8'h81)
        `CHK(pin_out[1], 8'h81)
        `CHK(pin_oe[2], 8'h20)
        `CHK(pin_oe[3], 8'h40)
        `CHK(pin_pullup[1], 8'h02)
        rdchk(8'h10, 32'hbd);
        wr(8'h18, 32'hff);
        rdchk(8'h10, 32'ha5);
        wr(8'h18, 0);
        periph_drive <= '0;
        wr(OFF_PIN_MUX, 0);
        $display("t_periph done");
    endtask
    task automatic t_kbi();
        wr(OFF_KBI_SEL, 32'hf0f);
        ext_val <= {5{8'h5a}};
        repeat (4) @(posedge hclk);
        `CHK(periph_sense.keyboard_interrupt_one_in, 8'h0a)
        `CHK(periph_sense.keyboard_interrupt_two_in, 4'ha)
        `CHK(periph_sense, ({8'h0a, 4'ha, 1'b1, 4'h5, 1'b0, 1'b1, 1'b0, 1'b1}))
        rdchk(OFF_KBI_SEL, 32'hf0f);
        $display("t_kbi done");
    endtask
    initial begin
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_reset();
        t_gpio();
        t_pullup();
        t_periph();
        t_kbi();
        conclude();
    end
endmodule
